// *** fpm_meter.sv ***
// fuel pulse meter, flow rate, scale-factor entry and fan speed deviation statistics
// assumes apb master on clk, meter pins asynchronous, speed/key/date inputs on clk
//
// How it works
// - setpoint output selects zero-based or live-zero range by control bit
// - each fuel holds a pulses-per-unit factor with its own unit choice
// - factor has five fractional digits for cubic feet, four otherwise
// - digit entry: select changes digit, enter advances or commits, escape leaves
// - each fuel has a clearable total and a never-cleared total
// - clearing a fuel total records the current date for that fuel
// - flow rate window closes between one and ten seconds
// - ten seconds without a pulse force flow rate to zero
// - reported flow rate is smoothed over successive results
// - pulses up to 300 Hz are counted without loss
// - largest static speed deviation at command end is kept
// - largest ramp versus measured speed deviation is kept
// - counters of command ends above 0.3 and 0.5 percent deviation
// - statistics read-only, cleared by reset or lockout reset
// - statistics accumulate only in operating position
// - percentages refer to full scale speed captured at 95 percent command
`timescale 1ns/1ns
`default_nettype none
`include "fpm_regs.svh"

module fpm_meter
  import fpm_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `FPM_MS_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register bus
  input wire fpm_apb_req_t apb_req,
  output fpm_apb_rsp_t apb_rsp,
  // meter pins
  input wire logic gas_pulse,
  input wire logic oil_pulse,
  // operator keys and calendar
  input wire fpm_keys_t keys,
  input wire logic [15:0] date_now,
  // variable_speed_drive loop
  input wire logic [11:0] drive_cmd,
  input wire logic drive_busy,
  input wire logic speed_stable,
  input wire logic [15:0] speed_meas,
  input wire logic [15:0] ramp_speed,
  input wire logic burner_operating,
  input wire logic lockout_reset,
  // drive setpoint current code
  output logic [11:0] setpoint_code
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] bcd_to_bin(input logic [7:0][3:0] d);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 7; i >= 0; i--) begin
      v = 32'((v << 3) + (v << 1)) + {28'h0, d[i]};
    end
    return v;
  endfunction

  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? 16'(a - b) : 16'(b - a);
  endfunction

  fpm_state_t r;
  fpm_state_t n;
  logic [1:0] edge_q;
  logic [1:0] clr;
  logic [1:0] drain;
  logic [31:0] entry_val;
  logic [15:0] dev_dyn;
  logic [15:0] dev_stat;
  logic cmd_end;
  logic flow_pulse;
  logic ms_tick;
  logic [11:0] win_tot;
  logic [32:0] rem_sh;
  logic [31:0] q_new;
  logic [31:0] dev_x;
  logic [31:0] fs_x;
  logic setup;
  logic access_wr;
  logic std_req;

  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.prdata = r.prdata;
  assign apb_rsp.pslverr = r.pslverr & apb_req.psel & apb_req.penable;
  assign setpoint_code = r.setpoint;
  assign setup = apb_req.psel & ~apb_req.penable;
  assign access_wr = apb_req.psel & apb_req.penable & apb_req.pwrite;

  always_comb begin
    n = r;
    edge_q = 2'b00;
    drain = 2'b00;
    clr = 2'b00;
    entry_val = bcd_to_bin(r.scr);
    dev_dyn = abs_diff(ramp_speed, speed_meas);
    dev_stat = abs_diff(ramp_speed, speed_meas);
    cmd_end = r.busy_d & ~drive_busy;
    ms_tick = (r.ms_cnt == 18'(MS_CYCLES - 1));
    flow_pulse = 1'b0;
    win_tot = 12'h0;
    rem_sh = 33'h0;
    q_new = 32'h0;
    dev_x = 32'({16'h0, dev_stat} * `FPM_DEV_SCALE);
    fs_x = {16'h0, r.fs};
    std_req = 1'b0;

    // ----------------------------------------------------------------
    // meter pins: three stages, level moves once stages two and three agree
    // ----------------------------------------------------------------
    for (int c = 0; c < 2; c++) begin
      n.sync[c] = {r.sync[c][1:0], (c == 0) ? gas_pulse : oil_pulse};
      if (r.sync[c][1] == r.sync[c][2]) begin
        n.lvl[c] = r.sync[c][2];
      end
      edge_q[c] = n.lvl[c] & ~r.lvl[c];
    end

    // ----------------------------------------------------------------
    // apb registers
    // ----------------------------------------------------------------
    n.pslverr = 1'b0;
    if (setup) begin
      n.prdata = 32'h0;
      unique case (apb_req.paddr)
        `FPM_OFS_CTRL: n.prdata = {27'h0, r.std_pend, 2'b00, r.oil_sel, r.live_zero};
        `FPM_OFS_STATUS: n.prdata = {24'h0, r.div_busy, r.idx, r.ent_fuel, 1'b0, r.ent};
        `FPM_OFS_PPU_GAS: n.prdata = {r.unit[0], r.ppu[0][30:0]};
        `FPM_OFS_PPU_OIL: n.prdata = {r.unit[1], r.ppu[1][30:0]};
        `FPM_OFS_VOL_GAS: n.prdata = r.vol[0];
        `FPM_OFS_VOL_OIL: n.prdata = r.vol[1];
        `FPM_OFS_VOLR_GAS: n.prdata = r.volr[0];
        `FPM_OFS_VOLR_OIL: n.prdata = r.volr[1];
        `FPM_OFS_DATE_GAS: n.prdata = {16'h0, r.date[0]};
        `FPM_OFS_DATE_OIL: n.prdata = {16'h0, r.date[1]};
        `FPM_OFS_FLOW: n.prdata = r.flow;
        `FPM_OFS_FULL_SCALE: n.prdata = {16'h0, r.fs};
        `FPM_OFS_MAX_STAT: n.prdata = {16'h0, r.max_stat};
        `FPM_OFS_MAX_DYN: n.prdata = {16'h0, r.max_dyn};
        `FPM_OFS_NUM_DEV03: n.prdata = {16'h0, r.num03};
        `FPM_OFS_NUM_DEV05: n.prdata = {16'h0, r.num05};
        default: n.pslverr = 1'b1;
      endcase
    end
    if (access_wr && apb_req.paddr == `FPM_OFS_CTRL) begin
      n.live_zero = apb_req.pwdata[`FPM_CTRL_LIVE_ZERO];
      n.oil_sel = apb_req.pwdata[`FPM_CTRL_OIL_SEL];
      clr[0] = apb_req.pwdata[`FPM_CTRL_CLR_GAS];
      clr[1] = apb_req.pwdata[`FPM_CTRL_CLR_OIL];
      std_req = apb_req.pwdata[`FPM_CTRL_STANDARDIZE];
      n.std_pend = r.std_pend | std_req;
    end

    // ----------------------------------------------------------------
    // setpoint current code
    // ----------------------------------------------------------------
    if (r.live_zero) begin
      n.setpoint = `FPM_LZ_OFS + 12'(({12'h0, drive_cmd} * `FPM_LZ_SPAN) >> 12);
    end else begin
      n.setpoint = drive_cmd;
    end

    // ----------------------------------------------------------------
    // scale factor digit entry
    // ----------------------------------------------------------------
    unique case (r.ent)
      FPM_ENT_IDLE: begin
        if (keys.start) begin
          n.ent = FPM_ENT_UNIT;
          n.ent_fuel = keys.fuel;
          n.scr_unit = r.unit[keys.fuel];
          n.scr = '0;
          n.idx = 3'h0;
        end
      end
      FPM_ENT_UNIT: begin
        if (keys.esc) begin
          n.ent = FPM_ENT_IDLE;
        end else if (keys.enter) begin
          n.ent = FPM_ENT_DIGIT;
        end else if (keys.sel) begin
          n.scr_unit = ~r.scr_unit;
        end
      end
      FPM_ENT_DIGIT: begin
        if (keys.esc) begin
          n.ent = FPM_ENT_IDLE;
        end else if (keys.enter && r.idx == 3'h7) begin
          n.ent = FPM_ENT_IDLE;
          n.ppu[r.ent_fuel] = entry_val;
          n.unit[r.ent_fuel] = r.scr_unit;
        end else if (keys.enter) begin
          n.idx = 3'(r.idx + 3'h1);
        end else if (keys.sel) begin
          n.scr[3'h7 - r.idx] = (r.scr[3'h7 - r.idx] == 4'h9) ? 4'h0
                                : 4'(r.scr[3'h7 - r.idx] + 4'h1);
        end
      end
      default: n.ent = FPM_ENT_IDLE;
    endcase

    // ----------------------------------------------------------------
    // volume totals: each pulse adds one in factor units, a unit drains per cycle
    // ----------------------------------------------------------------
    for (int c = 0; c < 2; c++) begin
      drain[c] = (r.ppu[c] != 32'h0) && (r.acc[c] >= r.ppu[c]);
      n.acc[c] = r.acc[c] - (drain[c] ? r.ppu[c] : 32'h0);
      if (edge_q[c]) begin
        // cubic feet carry five fractional digits
        n.acc[c] = n.acc[c] + ((c == 0 && r.unit[0]) ? `FPM_STEP_5FRAC
                                                     : `FPM_STEP_4FRAC);
      end
      n.vol[c] = r.vol[c] + {31'h0, drain[c]};
      if (clr[c]) begin
        n.volr[c] = {31'h0, drain[c]};
        n.date[c] = date_now;
      end else begin
        n.volr[c] = r.volr[c] + {31'h0, drain[c]};
      end
    end

    // ----------------------------------------------------------------
    // flow rate of the selected fuel, pulses per minute
    // ----------------------------------------------------------------
    flow_pulse = r.oil_sel ? edge_q[1] : edge_q[0];
    n.ms_cnt = ms_tick ? 18'h0 : 18'(r.ms_cnt + 18'h1);
    if (ms_tick) begin
      if (r.win_ms != 14'(`FPM_WIN_MAX_MS)) begin
        n.win_ms = 14'(r.win_ms + 14'h1);
      end
      if (r.idle_ms != 14'(`FPM_IDLE_MS)) begin
        n.idle_ms = 14'(r.idle_ms + 14'h1);
      end
    end
    win_tot = 12'(r.win_cnt + {11'h0, flow_pulse});
    if (flow_pulse) begin
      n.idle_ms = 14'h0;
      n.win_cnt = win_tot;
    end
    if (!r.div_busy && ((flow_pulse && r.win_ms >= 14'(`FPM_WIN_MIN_MS))
        || r.win_ms == 14'(`FPM_WIN_MAX_MS))) begin
      n.win_ms = 14'h0;
      n.win_cnt = 12'h0;
      if (win_tot != 12'h0) begin
        n.div_busy = 1'b1;
        n.div_cnt = 6'h0;
        n.quo = 32'({20'h0, win_tot} * `FPM_PER_MIN);
        n.rem = 33'h0;
        n.divisor = r.win_ms;
      end
    end
    if (r.div_busy) begin
      rem_sh = {r.rem[31:0], r.quo[31]};
      if (rem_sh >= {19'h0, r.divisor}) begin
        n.rem = rem_sh - {19'h0, r.divisor};
        q_new = {r.quo[30:0], 1'b1};
      end else begin
        n.rem = rem_sh;
        q_new = {r.quo[30:0], 1'b0};
      end
      n.quo = q_new;
      n.div_cnt = 6'(r.div_cnt + 6'h1);
      if (r.div_cnt == 6'h1f) begin
        n.div_busy = 1'b0;
        if (r.flow == 32'h0) begin
          n.flow = q_new;
        end else begin
          n.flow = r.flow - (r.flow >> 2) + (q_new >> 2);
        end
      end
    end
    if (r.idle_ms == 14'(`FPM_IDLE_MS)) begin
      n.flow = 32'h0;
    end

    // ----------------------------------------------------------------
    // full scale speed and deviation statistics
    // ----------------------------------------------------------------
    n.busy_d = drive_busy;
    if (r.std_pend && speed_stable) begin
      n.fs = speed_meas;
      n.std_pend = std_req; // a request in the capture cycle stays pending
    end
    if (burner_operating) begin
      if (drive_busy && dev_dyn > r.max_dyn) begin
        n.max_dyn = dev_dyn;
      end
      if (cmd_end) begin
        if (dev_stat > r.max_stat) begin
          n.max_stat = dev_stat;
        end
        if (dev_x > 32'(fs_x * `FPM_DEV_LOW)) begin
          n.num03 = 16'(r.num03 + 16'h1);
        end
        if (dev_x > 32'(fs_x * `FPM_DEV_HIGH)) begin
          n.num05 = 16'(r.num05 + 16'h1);
        end
      end
    end
    if (lockout_reset) begin
      n.max_stat = 16'h0;
      n.max_dyn = 16'h0;
      n.num03 = 16'h0;
      n.num05 = 16'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      r <= '0;
      r.ppu <= {`FPM_PPU_RESET, `FPM_PPU_RESET};
      r.ent <= FPM_ENT_IDLE;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_setpoint_live_zero: assert property (r.live_zero |=> setpoint_code >= 12'h333)
    else $error("live-zero setpoint below offset");
  a_entry_commit: assert property ((r.ent == FPM_ENT_DIGIT && keys.enter
      && !keys.esc && r.idx == 3'h7) |=> (r.ent == FPM_ENT_IDLE
      && r.ppu[$past(r.ent_fuel)] == $past(entry_val)))
    else $error("digit entry did not commit");
  a_entry_escape: assert property ((r.ent != FPM_ENT_IDLE && keys.esc)
      |=> r.ent == FPM_ENT_IDLE)
    else $error("escape did not leave entry");
  a_clear_gas_date: assert property ((clr[0] && !drain[0])
      |=> (r.volr[0] == 32'h0 && r.date[0] == $past(date_now)))
    else $error("gas clear lost total or date");
  a_total_keeps: assert property (r.vol[1] <= n.vol[1] && r.vol[0] <= n.vol[0])
    else $error("non-clearable total decreased");
  a_idle_zero: assert property ((r.idle_ms == 14'h2710 && !flow_pulse)
      |=> r.flow == 32'h0)
    else $error("flow not zero after idle");
  a_window_bound: assert property (r.win_ms <= 14'h2710)
    else $error("flow window longer than ten seconds");
  a_stats_frozen: assert property ((!burner_operating && !lockout_reset)
      |=> ($stable(r.max_dyn) && $stable(r.num03) && $stable(r.max_stat)))
    else $error("statistics moved outside operation");
  a_lockout_clear: assert property (lockout_reset |=> (r.max_stat == 16'h0
      && r.num05 == 16'h0 && r.max_dyn == 16'h0))
    else $error("lockout did not clear statistics");
  a_count_order: assert property (r.num05 <= r.num03)
    else $error("0.5 percent count above 0.3 percent count");
  a_max_dyn_track: assert property (burner_operating && drive_busy
      && !lockout_reset |=> r.max_dyn >= $past(dev_dyn))
    else $error("dynamic maximum missed a deviation");

endmodule // fpm_meter

`default_nettype wire

// *** fpm_meter_model.sv ***
// model of the two pulse-output fuel meters facing the block
// assumes go levels from the bench, changed just after a rising clk edge
`timescale 1ns/1ns
`default_nettype none

module fpm_meter_model #(
  parameter int PERIOD = 200
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // run requests, bit 0 gas, bit 1 oil
  input wire logic [1:0] go,
  // meter pins and count of pulses sent
  output logic [1:0] pin,
  output logic [1:0][15:0] sent
);
  logic [1:0][15:0] phase;

  // ----------------------------------------------------------------
  // one pulse per period while running, pin idles low
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (!rstn) begin
        phase[i] <= '0;
        pin[i] <= 1'b0;
        sent[i] <= '0;
      end else if (phase[i] != 16'h0000) begin
        phase[i] <= phase[i] - 16'h0001;
        pin[i] <= (phase[i] > 16'(PERIOD - 4));
      end else if (go[i]) begin
        phase[i] <= 16'(PERIOD - 1);
        pin[i] <= 1'b1;
        sent[i] <= sent[i] + 16'h0001;
      end
    end
  end
endmodule // fpm_meter_model

`default_nettype wire

// *** fpm_pkg.sv ***
// types shared by the fuel meter block
// assumes fpm_regs.svh for all numeric constants
`default_nettype none

package fpm_pkg;

  // ----------------------------------------------------------------
  // bus and key carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } fpm_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } fpm_apb_rsp_t;

  typedef struct packed {
    logic start;
    logic fuel;
    logic sel;
    logic enter;
    logic esc;
  } fpm_keys_t;

  typedef enum logic [1:0] {
    FPM_ENT_IDLE = 2'b00,
    FPM_ENT_UNIT = 2'b01,
    FPM_ENT_DIGIT = 2'b11
  } fpm_ent_t;

  // ----------------------------------------------------------------
  // whole state of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0][2:0] sync;
    logic [1:0] lvl;
    logic live_zero;
    logic oil_sel;
    logic std_pend;
    logic [11:0] setpoint;
    logic [1:0] unit;
    logic [1:0][31:0] ppu;
    logic [1:0][31:0] acc;
    logic [1:0][31:0] vol;
    logic [1:0][31:0] volr;
    logic [1:0][15:0] date;
    fpm_ent_t ent;
    logic ent_fuel;
    logic [2:0] idx;
    logic [7:0][3:0] scr;
    logic scr_unit;
    logic [17:0] ms_cnt;
    logic [13:0] win_ms;
    logic [13:0] idle_ms;
    logic [11:0] win_cnt;
    logic div_busy;
    logic [5:0] div_cnt;
    logic [31:0] quo;
    logic [32:0] rem;
    logic [13:0] divisor;
    logic [31:0] flow;
    logic [15:0] fs;
    logic [15:0] max_stat;
    logic [15:0] max_dyn;
    logic [15:0] num03;
    logic [15:0] num05;
    logic busy_d;
    logic [31:0] prdata;
    logic pslverr;
  } fpm_state_t;

endpackage

`default_nettype wire

// *** fpm_regs.svh ***
// register offsets, field positions, reset values and timing counts of the fuel meter block
// assumes a 250 MHz system clock and a 32-bit apb register bus
`ifndef FPM_REGS_SVH
`define FPM_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define FPM_OFS_CTRL 8'h00
`define FPM_OFS_STATUS 8'h04
`define FPM_OFS_PPU_GAS 8'h08
`define FPM_OFS_PPU_OIL 8'h0c
`define FPM_OFS_VOL_GAS 8'h10
`define FPM_OFS_VOL_OIL 8'h14
`define FPM_OFS_VOLR_GAS 8'h18
`define FPM_OFS_VOLR_OIL 8'h1c
`define FPM_OFS_DATE_GAS 8'h20
`define FPM_OFS_DATE_OIL 8'h24
`define FPM_OFS_FLOW 8'h28
`define FPM_OFS_FULL_SCALE 8'h2c
`define FPM_OFS_MAX_STAT 8'h30
`define FPM_OFS_MAX_DYN 8'h34
`define FPM_OFS_NUM_DEV03 8'h38
`define FPM_OFS_NUM_DEV05 8'h3c

// ----------------------------------------------------------------
// control register fields and the factor unit bit
// ----------------------------------------------------------------
`define FPM_CTRL_LIVE_ZERO 0
`define FPM_CTRL_OIL_SEL 1
`define FPM_CTRL_CLR_GAS 2
`define FPM_CTRL_CLR_OIL 3
`define FPM_CTRL_STANDARDIZE 4
`define FPM_PPU_UNIT_BIT 31

// ----------------------------------------------------------------
// reset values and scaling
// ----------------------------------------------------------------
`define FPM_PPU_RESET 32'h0000_2710
`define FPM_STEP_4FRAC 32'h0000_2710
`define FPM_STEP_5FRAC 32'h0001_86a0
`define FPM_LZ_OFS 12'h333
`define FPM_LZ_SPAN 24'h000ccc
`define FPM_DEV_SCALE 32'h0000_03e8
`define FPM_DEV_LOW 32'h0000_0003
`define FPM_DEV_HIGH 32'h0000_0005
`define FPM_PER_MIN 32'h0000_ea60

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FPM_CLK_NS 4
`define FPM_MS_NS 1000000
`define FPM_MS_CYC (`FPM_MS_NS / `FPM_CLK_NS)
`define FPM_WIN_MIN_S 1
`define FPM_WIN_MAX_S 10
`define FPM_IDLE_S 10
`define FPM_WIN_MIN_MS (`FPM_WIN_MIN_S * 1000)
`define FPM_WIN_MAX_MS (`FPM_WIN_MAX_S * 1000)
`define FPM_IDLE_MS (`FPM_IDLE_S * 1000)

`endif

// *** testbench.sv ***
// self-checking bench of the fuel meter block
// assumes 1 ms shortened to MS cycles and meter pulses from fpm_meter_model
`timescale 1ns/1ns
`default_nettype none
`include "fpm_regs.svh"

module testbench import fpm_pkg::*;;
  localparam int MS = 2;
  localparam int PER = 200;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} fpm_tb_row_t;
  typedef struct packed {logic lz; logic [11:0] c; logic [11:0] s;} fpm_tb_sp_t;
  localparam fpm_tb_row_t REG_ROWS [8] = '{
    '{`FPM_OFS_CTRL, 32'h0, 1'b0}, '{`FPM_OFS_PPU_GAS, `FPM_PPU_RESET, 1'b0},
    '{`FPM_OFS_PPU_OIL, `FPM_PPU_RESET, 1'b0}, '{`FPM_OFS_VOL_GAS, 32'h0, 1'b0},
    '{`FPM_OFS_VOLR_OIL, 32'h0, 1'b0}, '{`FPM_OFS_FLOW, 32'h0, 1'b0},
    '{`FPM_OFS_NUM_DEV05, 32'h0, 1'b0}, '{8'h40, 32'h0, 1'b1}};
  localparam fpm_tb_sp_t SP_ROWS [4] = '{'{1'b0, 12'habc, 12'habc},
    '{1'b1, 12'h000, 12'h333}, '{1'b1, 12'hfff, 12'hffe}, '{1'b0, 12'hfff, 12'hfff}};
  localparam logic [4:0] K_OIL = 5'h18;
  localparam logic [4:0] K_SEL = 5'h04;
  localparam logic [4:0] K_ENT = 5'h02;
  localparam logic [4:0] K_ESC = 5'h01;
  localparam logic [4:0] K_GAS = 5'h10;

  logic clk, rstn, drive_busy, speed_stable, burner_operating, lockout_reset;
  logic [1:0] go, pin;
  logic [1:0][15:0] sent;
  logic [15:0] date_now, speed_meas, ramp_speed;
  logic [11:0] drive_cmd, setpoint_code;
  logic [31:0] q;
  logic e;
  fpm_apb_req_t req;
  fpm_apb_rsp_t rsp;
  fpm_keys_t keys;
  int bad_count, checks_done;

  fpm_meter #(.MS_CYCLES(MS)) DUT (.clk(clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp),
    .gas_pulse(pin[0]), .oil_pulse(pin[1]), .keys(keys), .date_now(date_now),
    .drive_cmd(drive_cmd), .drive_busy(drive_busy), .speed_stable(speed_stable),
    .speed_meas(speed_meas), .ramp_speed(ramp_speed), .burner_operating(burner_operating),
    .lockout_reset(lockout_reset), .setpoint_code(setpoint_code));
  fpm_meter_model #(.PERIOD(PER)) meters (.clk(clk), .rstn(rstn), .go(go), .pin(pin),
    .sent(sent));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      tally_and_finish;
    end
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    cmp(what, x, q);
    cmp("pslverr", {31'h0, xe}, {31'h0, e});
  endtask

  task automatic key(input logic [4:0] k);
    @(posedge clk);
    keys <= fpm_keys_t'(k);
    @(posedge clk);
    keys <= '0;
  endtask

  // start, switch unit, then digits 0002 0000 most significant first
  task automatic entry(input logic [4:0] k);
    key(k);
    key(K_SEL);
    key(K_ENT);
    for (int i = 0; i < 8; i++) begin
      if (i == 3) begin
        key(K_SEL);
        key(K_SEL);
      end
      key(K_ENT);
    end
  endtask

  task automatic pulses(input int f, input int n);
    int t;
    logic [15:0] goal;
    goal = sent[f] + 16'(n);
    t = 0;
    @(posedge clk);
    go[f] <= 1'b1;
    while (sent[f] !== goal && t < 50000) begin
      @(posedge clk);
      t++;
    end
    go[f] <= 1'b0;
    if (t >= 50000) begin
      bad_count++;
      tally_and_finish;
    end
    repeat (PER + 20) @(posedge clk);
  endtask

  task automatic cmd(input logic [15:0] dyn, input logic [15:0] fin);
    @(posedge clk);
    drive_busy <= 1'b1;
    speed_meas <= dyn;
    repeat (3) @(posedge clk);
    speed_meas <= fin;
    repeat (3) @(posedge clk);
    drive_busy <= 1'b0;
    repeat (3) @(posedge clk);
    speed_meas <= 16'h03e8;
  endtask

  task automatic stats(input logic [15:0] s, input logic [15:0] d, input logic [15:0] c3,
                       input logic [15:0] c5);
    rd("max static", `FPM_OFS_MAX_STAT, {16'h0, s}, 1'b0);
    rd("max dynamic", `FPM_OFS_MAX_DYN, {16'h0, d}, 1'b0);
    rd("count low", `FPM_OFS_NUM_DEV03, {16'h0, c3}, 1'b0);
    rd("count high", `FPM_OFS_NUM_DEV05, {16'h0, c5}, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    tally_and_finish;
  end

  initial begin
    {rstn, drive_busy, speed_stable, burner_operating, lockout_reset} = '0;
    {go, req, keys, drive_cmd} = '0;
    date_now = 16'h1234;
    speed_meas = 16'h03e8;
    ramp_speed = 16'h03e8;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    foreach (REG_ROWS[i]) begin
      rd("reset read", REG_ROWS[i].a, REG_ROWS[i].d, REG_ROWS[i].e);
    end
    foreach (SP_ROWS[i]) begin
      apb(1'b1, `FPM_OFS_CTRL, {31'h0, SP_ROWS[i].lz});
      drive_cmd <= SP_ROWS[i].c;
      repeat (2) @(posedge clk);
      cmp("setpoint", {20'h0, SP_ROWS[i].s}, {20'h0, setpoint_code});
    end
    // gas totals, then clear of the resettable one
    pulses(0, 3);
    rd("gas total", `FPM_OFS_VOL_GAS, 32'h3, 1'b0);
    rd("gas clearable", `FPM_OFS_VOLR_GAS, 32'h3, 1'b0);
    apb(1'b1, `FPM_OFS_CTRL, 32'h4);
    rd("gas cleared", `FPM_OFS_VOLR_GAS, 32'h0, 1'b0);
    rd("gas kept", `FPM_OFS_VOL_GAS, 32'h3, 1'b0);
    rd("gas date", `FPM_OFS_DATE_GAS, 32'h1234, 1'b0);
    // oil factor entry in gallons: 0002.0000, then an abandoned entry
    entry(K_OIL);
    rd("oil factor", `FPM_OFS_PPU_OIL, 32'h8000_4e20, 1'b0);
    key(K_OIL);
    key(K_ENT);
    key(K_SEL);
    key(K_ESC);
    rd("oil factor kept", `FPM_OFS_PPU_OIL, 32'h8000_4e20, 1'b0);
    pulses(1, 2);
    rd("oil total", `FPM_OFS_VOL_OIL, 32'h1, 1'b0);
    // gas flow at 600 per minute, then silence
    apb(1'b1, `FPM_OFS_CTRL, 32'h0);
    pulses(0, 25);
    apb(1'b0, `FPM_OFS_FLOW, 32'h0);
    checks_done++;
    if (q < 32'h1c2 || q > 32'h2bc || $isunknown(q)) begin
      bad_count++;
      $display("unexpected flow expected 1c2..2bc seen %h", q);
    end
    repeat (10000 * MS + 1000) @(posedge clk);
    rd("flow idle", `FPM_OFS_FLOW, 32'h0, 1'b0);
    // gas factor 0.20000 per cubic foot: one pulse is five units
    entry(K_GAS);
    rd("gas factor", `FPM_OFS_PPU_GAS, 32'h8000_4e20, 1'b0);
    pulses(0, 1);
    rd("gas cubic feet", `FPM_OFS_VOL_GAS, 32'h21, 1'b0);
    // speed statistics
    burner_operating <= 1'b1;
    apb(1'b1, `FPM_OFS_CTRL, 32'h10);
    speed_stable <= 1'b1;
    @(posedge clk);
    speed_stable <= 1'b0;
    rd("full scale", `FPM_OFS_FULL_SCALE, 32'h3e8, 1'b0);
    cmd(16'h03de, 16'h03e4);
    cmd(16'h03f0, 16'h03ee);
    stats(16'h6, 16'ha, 16'h2, 16'h1);
    burner_operating <= 1'b0;
    cmd(16'h0384, 16'h0384);
    stats(16'h6, 16'ha, 16'h2, 16'h1);
    apb(1'b1, `FPM_OFS_MAX_STAT, 32'h0);
    rd("stat read only", `FPM_OFS_MAX_STAT, 32'h6, 1'b0);
    lockout_reset <= 1'b1;
    @(posedge clk);
    lockout_reset <= 1'b0;
    stats(16'h0, 16'h0, 16'h0, 16'h0);
    // system reset in mid-run clears the statistics too
    burner_operating <= 1'b1;
    cmd(16'h03de, 16'h03e4);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    stats(16'h0, 16'h0, 16'h0, 16'h0);
    tally_and_finish;
  end
endmodule // testbench

`default_nettype wire
